//--- inc/gcc_pkg.sv
package gcc_pkg;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int ACQ_FAST_US = 300;
  localparam real ACQ_SLOW_MS = 6.0;
  localparam int ACQ_FAST_CYC = ACQ_FAST_US * CLK_MHZ;
  localparam int ACQ_SLOW_CYC = int'($floor(ACQ_SLOW_MS * 1000.0 * CLK_MHZ));
  localparam real REF_MIN_MHZ = 1.5;
  localparam int REF_LOST_CYC = 2 * int'($ceil(CLK_MHZ / REF_MIN_MHZ));
  localparam int LOCK_W = 20;
  localparam int IDLE_W = 8;

  // Structure of the conditioning block
  localparam int DLY_STEP_PS = 160;
  localparam int DLY_W = 5;
  localparam int NUM_SE = 3;
  localparam int NUM_DIFF = 2;
  localparam int NUM_PAD = NUM_SE + NUM_DIFF;
  localparam int SRC_W = 3;
  localparam logic [SRC_W-1:0] SRC_CORE = 3'h5;
  localparam int NUM_GLB = 3;
  localparam int NUM_DIV = 5;
  localparam int DIV_W = 5;
  localparam int DIV_OUT0 = 2;
  localparam int NUM_DLY = 6;
  localparam int NUM_PH = 3;
  localparam int PH_W = 2;
  localparam logic [1:0] MUX_CFG_NET = 2'h1;

  // Register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_SHIFT = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_CFG0 = 12'h00c;
  localparam int CFG_WORDS = 3;
  localparam int CTRL_DYN = 0;
  localparam int CTRL_UPD = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int SHIFT_DATA = 0;
  localparam int ST_LOCK = 0;
  localparam int ST_AWAKE = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_SRC = 3;
  localparam int ST_DYN = 4;
  localparam int CNT_W = 7;

  typedef struct packed {
    logic [NUM_DLY-1:0][DLY_W-1:0] dly;
    logic [NUM_DIV-1:0][DIV_W-1:0] div;
    logic [NUM_PH-1:0][PH_W-1:0] phase;
    logic [NUM_GLB-1:0][SRC_W-1:0] src;
    logic [1:0] core_en;
    logic fb_external;
    logic acquire_mode;
    logic [1:0] mux_cfg;
  } gcc_cfg_t;
  localparam int CFG_W = $bits(gcc_cfg_t);

  typedef struct packed {
    logic [NUM_GLB-1:0][NUM_PAD-1:0] pad;
    logic [NUM_GLB-1:0] core_net;
    logic mux_net;
  } gcc_pins_t;

  typedef struct packed {
    logic third_core;
    logic second_core;
    logic third;
    logic second;
    logic first;
  } gcc_clks_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gcc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gcc_apb_rsp_t;

  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_LAST_RISE = 2'b01,
    SW_LAST_FALL = 2'b11,
    SW_HOLD = 2'b10
  } gcc_sw_t;

  typedef struct packed {
    gcc_pins_t s1, s2, s3, filt;
    logic dyn_mode;
    logic [1:0] sw_sel;
    logic [CFG_W-1:0] shadow;
    gcc_cfg_t dyn_cfg;
    logic [CNT_W-1:0] shift_cnt;
    logic [31:0] prdata;
    logic pslverr;
    logic armed;
    logic [LOCK_W-1:0] lock_cnt;
    logic lock;
    logic ref_prev;
    logic [IDLE_W-1:0] ref_idle;
    logic [NUM_GLB-1:0][DIV_W-1:0] div_cnt;
    gcc_clks_t clks;
    gcc_sw_t sw_state;
    logic sw_src;
    logic sw_tgt;
    logic hold_cnt;
    logic [1:0] in_prev;
    logic [1:0] sel_s0;
    logic [1:0] sel_s1;
    logic sel_out;
  } gcc_state_t;
  localparam gcc_state_t ST_RST = '0;
endpackage

//--- hw/gcc_top.sv
// What this block does
// - Each global and the reference pick three single-ended pins, two differential, or fabric.
// - Holds loop, three phase selectors, six delays, five dividers, one shift register.
// - Settings come from static bits or a serially written shift register.
// - Loop reference comes only from the A-group source of the first global.
// - One reference yields five derived clock outputs, three independent.
// - Feedback path selectable between internal and external.
// - Low sleep input disables the loop; power-down is the default.
// - Lock output goes high once the loop has locked.
// - Three distinct frequencies; second and third also reach core outputs.
// - Each of the five outputs has its own delay setting.
// - Feedback path has its own delay to advance outputs.
// - Each delay has up to 32 settings of 160 ps.
// - Lock within 300 us in fast mode, 6.0 ms in slow mode.
// - Source config 00 pairs first with third, 01 first with fabric net.
// - Select 0 passes input zero, select 1 passes input one.
// - Source config is static and also changeable by dynamic reconfiguration.
// - After a select change, one last full high pulse of the old clock.
// - Then the output stays low until the second new rising edge.
// - From that edge on the output follows the new clock, no runt pulses.
// - A used core output stops its global from serving as a buffer.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module gcc_top #(
  parameter int ACQ_FAST = gcc_pkg::ACQ_FAST_CYC,
  parameter int ACQ_SLOW = gcc_pkg::ACQ_SLOW_CYC,
  parameter gcc_pkg::gcc_cfg_t STATIC_CFG = '0
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // Register bus
  input wire gcc_pkg::gcc_apb_req_t apb_req,
  output gcc_pkg::gcc_apb_rsp_t apb_rsp,
  // Clock pins and fabric nets
  input wire gcc_pkg::gcc_pins_t pins,
  input wire logic pll_sleep_n,
  // Conditioned clocks and loop control
  output gcc_pkg::gcc_clks_t clk_out,
  output logic selected_net_out,
  output logic lock,
  output gcc_pkg::gcc_cfg_t cfg_out
);
  import gcc_pkg::*;

  gcc_state_t st_ff;
  gcc_state_t nxt_st;
  gcc_cfg_t cfg;
  logic [CFG_WORDS*32-1:0] cfg_words;
  logic [4:0] clk_v;
  logic ref_clk, in0, in1, old_clk, new_clk;
  logic rise0, rise1, rise_old, fall_old, rise_new, sel_old;
  logic access, done, wr, upd, mapped;
  logic [31:0] rdata;
  int lim;

  function automatic logic pick(input gcc_pins_t p, input int g, input logic [SRC_W-1:0] code);
    logic v;
    v = 1'b0;
    if (code < SRC_W'(NUM_PAD)) begin
      v = p.pad[g][code];
    end else if (code == SRC_CORE) begin
      v = p.core_net[g];
    end
    return v;
  endfunction

  // Dynamic settings replace the static ones only once software asks for it
  assign cfg = st_ff.dyn_mode ? st_ff.dyn_cfg : STATIC_CFG;
  assign cfg_words = {{(CFG_WORDS * 32 - CFG_W){1'b0}}, cfg};
  assign clk_v = st_ff.clks;
  assign lim = cfg.acquire_mode ? ACQ_SLOW : ACQ_FAST;

  assign ref_clk = pick(st_ff.filt, 0, cfg.src[0]);
  assign in0 = st_ff.clks.first;
  assign in1 = (cfg.mux_cfg == MUX_CFG_NET) ? st_ff.filt.mux_net : st_ff.clks.third;
  assign rise0 = in0 & ~st_ff.in_prev[0];
  assign rise1 = in1 & ~st_ff.in_prev[1];
  assign old_clk = st_ff.sw_src ? in1 : in0;
  assign new_clk = st_ff.sw_tgt ? in1 : in0;
  assign rise_old = old_clk & ~st_ff.in_prev[st_ff.sw_src];
  assign fall_old = ~old_clk & st_ff.in_prev[st_ff.sw_src];
  assign rise_new = new_clk & ~st_ff.in_prev[st_ff.sw_tgt];
  assign sel_old = st_ff.sw_src ? st_ff.sel_s1[1] : st_ff.sel_s0[1];

  // Bus: data is captured in the setup cycle so the access phase needs no wait
  assign access = apb_req.psel & apb_req.penable & ce;
  assign done = access & st_ff.armed;
  assign wr = done & apb_req.pwrite;
  assign upd = wr & (apb_req.paddr == ADDR_CTRL) & apb_req.pwdata[CTRL_UPD];
  assign apb_rsp = '{prdata: st_ff.prdata, pready: done, pslverr: done & st_ff.pslverr};

  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    case (apb_req.paddr)
      ADDR_CTRL: begin
        rdata[CTRL_DYN] = st_ff.dyn_mode;
        rdata[CTRL_SEL_LSB +: 2] = st_ff.sw_sel;
      end
      ADDR_SHIFT: begin
        rdata[CNT_W-1:0] = st_ff.shift_cnt;
      end
      ADDR_STATUS: begin
        rdata[ST_LOCK] = st_ff.lock;
        rdata[ST_AWAKE] = pll_sleep_n;
        rdata[ST_BUSY] = st_ff.sw_state != SW_RUN;
        rdata[ST_SRC] = st_ff.sw_src;
        rdata[ST_DYN] = st_ff.dyn_mode;
      end
      ADDR_CFG0, ADDR_CFG0 + 12'h004, ADDR_CFG0 + 12'h008: begin
        rdata = cfg_words[32 * int'((apb_req.paddr - ADDR_CFG0) >> 2) +: 32];
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    logic [NUM_GLB-1:0] second_pll_output;
    second_pll_output = '0;
    nxt_st = st_ff;

    // Pin inputs: a level counts only once stages two and three agree
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.filt = (st_ff.s2 & st_ff.s3) | (st_ff.filt & (st_ff.s2 ^ st_ff.s3));

    nxt_st.armed = apb_req.psel & ~done;
    if (apb_req.psel && !st_ff.armed) begin
      nxt_st.prdata = rdata;
      nxt_st.pslverr = ~mapped;
    end
    if (wr && apb_req.paddr == ADDR_CTRL) begin
      nxt_st.dyn_mode = apb_req.pwdata[CTRL_DYN];
      nxt_st.sw_sel = apb_req.pwdata[CTRL_SEL_LSB +: 2];
    end
    if (upd) begin
      nxt_st.dyn_cfg = gcc_cfg_t'(st_ff.shadow);
      nxt_st.shift_cnt = '0;
    end
    if (wr && apb_req.paddr == ADDR_SHIFT) begin
      nxt_st.shadow = {st_ff.shadow[CFG_W-2:0], apb_req.pwdata[SHIFT_DATA]};
      nxt_st.shift_cnt = st_ff.shift_cnt + 1'b1;
    end

    // Loop: a stalled reference or new settings force a fresh acquisition
    nxt_st.ref_prev = ref_clk;
    if (ref_clk && !st_ff.ref_prev) begin
      nxt_st.ref_idle = '0;
    end else if (st_ff.ref_idle != IDLE_W'(REF_LOST_CYC)) begin
      nxt_st.ref_idle = st_ff.ref_idle + 1'b1;
    end
    if (!pll_sleep_n || upd || st_ff.ref_idle == IDLE_W'(REF_LOST_CYC)) begin
      nxt_st.lock_cnt = '0;
      nxt_st.lock = 1'b0;
    end else if (32'(st_ff.lock_cnt) >= lim - 1) begin
      nxt_st.lock = 1'b1;
    end else begin
      nxt_st.lock_cnt = st_ff.lock_cnt + 1'b1;
    end

    // Locked: three dividers; unlocked: each global is a plain buffer unless its core output is used
    for (int k = 0; k < NUM_GLB; k++) begin
      if (!st_ff.lock) begin
        nxt_st.div_cnt[k] = '0;
        second_pll_output[k] = pick(st_ff.filt, k, cfg.src[k]);
        if (k > 0 && cfg.core_en[k-1]) begin
          second_pll_output[k] = 1'b0;
        end
      end else if (st_ff.div_cnt[k] == cfg.div[DIV_OUT0 + k]) begin
        nxt_st.div_cnt[k] = '0;
        second_pll_output[k] = ~clk_v[k];
      end else begin
        nxt_st.div_cnt[k] = st_ff.div_cnt[k] + 1'b1;
        second_pll_output[k] = clk_v[k];
      end
    end
    nxt_st.clks.first = second_pll_output[0];
    nxt_st.clks.second = second_pll_output[1];
    nxt_st.clks.third = second_pll_output[2];
    nxt_st.clks.second_core = st_ff.lock & cfg.core_en[0] & second_pll_output[1];
    nxt_st.clks.third_core = st_ff.lock & cfg.core_en[1] & second_pll_output[2];

    // Switch: select crosses into each input's own edge stream first
    nxt_st.in_prev = {in1, in0};
    if (rise0) begin
      nxt_st.sel_s0 = {st_ff.sel_s0[0], st_ff.sw_sel[0]};
    end
    if (rise1) begin
      nxt_st.sel_s1 = {st_ff.sel_s1[0], st_ff.sw_sel[0]};
    end
    case (st_ff.sw_state)
      SW_RUN: begin
        nxt_st.sel_out = old_clk;
        if (sel_old != st_ff.sw_src) begin
          nxt_st.sw_tgt = sel_old;
          nxt_st.sw_state = SW_LAST_RISE;
        end
      end
      SW_LAST_RISE: begin
        nxt_st.sel_out = old_clk;
        if (rise_old) begin
          nxt_st.sw_state = SW_LAST_FALL;
        end
      end
      SW_LAST_FALL: begin
        nxt_st.sel_out = old_clk;
        if (fall_old) begin
          nxt_st.hold_cnt = 1'b0;
          nxt_st.sw_state = SW_HOLD;
        end
      end
      SW_HOLD: begin
        nxt_st.sel_out = 1'b0;
        if (rise_new) begin
          if (st_ff.hold_cnt) begin
            nxt_st.sw_src = st_ff.sw_tgt;
            nxt_st.sel_out = 1'b1;
            nxt_st.sw_state = SW_RUN;
          end else begin
            nxt_st.hold_cnt = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.sw_state = SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_ff <= ST_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign clk_out = st_ff.clks;
  assign selected_net_out = st_ff.sel_out;
  assign lock = st_ff.lock;
  // Delay codes (five outputs plus feedback), dividers and feedback choice drive the analog loop
  assign cfg_out = cfg;

  default clocking dcb @(posedge clock iff ce); endclocking
  default disable iff (!rstn);

  sequence s_drain_done;
    st_ff.sw_state == SW_LAST_FALL ##1 st_ff.sw_state == SW_HOLD;
  endsequence
  sequence s_second_rise;
    st_ff.sw_state == SW_HOLD && st_ff.hold_cnt && rise_new;
  endsequence

  chk_sleep_unlock: assert property (!pll_sleep_n |=> !st_ff.lock)
    else $error("lock held while loop asleep");
  chk_lock_bound: assert property (!st_ff.lock && pll_sleep_n |-> 32'(st_ff.lock_cnt) < lim)
    else $error("acquisition count passed its bound");
  chk_lock_rise: assert property ($rose(st_ff.lock) |-> 32'($past(st_ff.lock_cnt)) == lim - 1)
    else $error("lock rose at wrong count");
  chk_switch_start: assert property (st_ff.sw_state == SW_RUN && sel_old != st_ff.sw_src
    |=> st_ff.sw_state == SW_LAST_RISE && st_ff.sw_tgt == $past(sel_old))
    else $error("switch did not start");
  chk_last_pulse: assert property (s_drain_done |-> !st_ff.sel_out)
    else $error("hold entered with output high");
  chk_hold_low: assert property (st_ff.sw_state == SW_HOLD |-> !st_ff.sel_out)
    else $error("output high during hold");
  chk_second_edge: assert property (s_second_rise
    |=> st_ff.sw_state == SW_RUN && st_ff.sel_out && st_ff.sw_src == $past(st_ff.sw_tgt))
    else $error("new clock not taken at second edge");
  chk_run_follow: assert property (st_ff.sw_state == SW_RUN && $past(st_ff.sw_state) == SW_RUN
    |-> st_ff.sel_out == $past(old_clk))
    else $error("output not following selected clock");
  chk_sync_wait: assert property (st_ff.sw_state == SW_RUN && sel_old == st_ff.sw_src
    |=> st_ff.sw_state == SW_RUN)
    else $error("switch began before select synchronised");
  chk_update_load: assert property (upd |=> st_ff.dyn_cfg == $past(st_ff.shadow))
    else $error("update did not load shift register");
  chk_core_excl: assert property (!st_ff.lock && cfg.core_en[0] |=> !st_ff.clks.second)
    else $error("global reused while core output in use");
endmodule // gcc_top

//--- verification/gcc_fabric_model.sv
`timescale 1ns/1ps
module gcc_fabric_model
  import gcc_pkg::*;
(
  // System clock and supply state
  input wire logic clock,
  input wire logic supply_ok,
  // Pins and sleep control towards the block
  output gcc_pkg::gcc_pins_t pins,
  output logic pll_sleep_n
);
  int t = 0;

  always_ff @(posedge clock) begin
    t <= t + 1;
  end

  // Every pad and core net source has its own half period, so a wrong pick shows in the toggle count
  always_comb begin
    for (int g = 0; g < NUM_GLB; g++) begin
      for (int i = 0; i < NUM_PAD; i++) begin
        pins.pad[g][i] = ((t / (6 + i)) % 2) == 1;
      end
      pins.core_net[g] = ((t / 11) % 2) == 1;
    end
    pins.mux_net = ((t / 7) % 2) == 1;
  end

  // Loop kept in power-down until the supply is reported valid
  assign pll_sleep_n = supply_ok;
endmodule // gcc_fabric_model

//--- verification/tb_glitchless_clock_conditioning.sv
`timescale 1ns/1ps
module tb_glitchless_clock_conditioning;
  import gcc_pkg::*;
  logic clock = 1'b0;
  logic rstn, ce, wake, dm, mon, prev, er;
  gcc_apb_req_t req;
  gcc_apb_rsp_t apb_rsp;
  gcc_pins_t pins;
  gcc_clks_t clk_out;
  gcc_cfg_t cfg_out, c;
  logic pll_sleep_n, selected_net_out, lock;
  logic [31:0] rd;
  int fail_count = 0;
  int n_tests = 0;
  int run = 0;
  int tc[6];

  always #4 clock = ~clock;

  gcc_top #(.ACQ_FAST(20), .ACQ_SLOW(40)) u_gcc_top (.clock(clock), .rstn(rstn), .ce(ce), .apb_req(req),
    .apb_rsp(apb_rsp), .pins(pins), .pll_sleep_n(pll_sleep_n), .clk_out(clk_out),
    .selected_net_out(selected_net_out), .lock(lock), .cfg_out(cfg_out));
  gcc_fabric_model u_gcc_fabric_model (.clock(clock), .supply_ok(wake), .pins(pins), .pll_sleep_n(pll_sleep_n));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [75:0] s, input logic [75:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic to(input int n);
    if (n >= 200) begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    n = 0;
    // The request stands until the rising edge that samples pready high
    do begin
      @(posedge clock);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 200);
    to(n);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // Let the completed write settle before anyone looks at its effect
    @(negedge clock);
  endtask

  // Toggles of every clock output and the switch output over a fixed window
  task automatic tgl();
    logic [5:0] p, v;
    tc = '{default: 0};
    p = {selected_net_out, clk_out};
    repeat (132) begin
      @(negedge clock);
      v = {selected_net_out, clk_out};
      for (int i = 0; i < 6; i++) tc[i] += int'(v[i] !== p[i]);
      p = v;
    end
  endtask

  task automatic ct(input int i, input int h);
    int e;
    e = (h == 0) ? 0 : 132 / h;
    chk(tc[i] <= e + 1 && tc[i] + 1 >= e, 1'b1);
  endtask

  function automatic int hs(input logic [2:0] x);
    return (x == SRC_CORE) ? 11 : 6 + int'(x);
  endfunction

  task automatic sw(input logic s, input logic f, input int h);
    int n;
    apb(1'b1, ADDR_CTRL, {28'h0, 1'b0, s, 1'b0, dm});
    if (f) begin
      n = 0;
      do begin
        apb(1'b0, ADDR_STATUS, 32'h0);
        n++;
      end while (rd[ST_BUSY] !== 1'b1 && n < 200);
      to(n);
      apb(1'b1, ADDR_CTRL, {28'h0, 1'b0, !s, 1'b0, dm});
    end
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while ((rd[ST_BUSY] !== 1'b0 || rd[ST_SRC] !== (s ^ f)) && n < 200);
    to(n);
    chk(rd[ST_SRC], s ^ f);
    tgl();
    ct(5, h);
  endtask

  task automatic lk(input int lim);
    @(posedge clock);
    wake <= 1'b1;
    repeat (lim - 2) @(negedge clock);
    chk(lock, 1'b0);
    repeat (12) @(negedge clock);
    chk(lock, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[1:0], 2'h3);
  endtask

  task automatic sl();
    @(posedge clock);
    wake <= 1'b0;
    repeat (3) @(negedge clock);
    chk(lock, 1'b0);
  endtask

  // Any level shorter than four system clock cycles is a runt pulse
  always @(negedge clock) begin
    if (selected_net_out !== prev) begin
      if (mon) chk(run >= 4, 1'b1);
      run = 0;
    end
    run++;
    prev = selected_net_out;
  end

  initial begin
    req = '0;
    rstn = 1'b0;
    ce = 1'b1;
    wake = 1'b0;
    dm = 1'b0;
    mon = 1'b0;
    void'($urandom(67));
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk(lock, 1'b0);
    chk(cfg_out, 76'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({er, rd}, 33'h100000000);
    mon = 1'b1;
    sw(1'b1, 1'b0, 6);
    sw(1'b0, 1'b1, 6);
    sw(1'b0, 1'b0, 6);
    mon = 1'b0;
    lk(20);
    sl();
    c = gcc_cfg_t'(76'({$urandom, $urandom, $urandom}));
    for (int g = 0; g < NUM_GLB; g++) c.src[g] = 3'($urandom % 6);
    c.core_en = 2'h0;
    c.acquire_mode = 1'b1;
    c.mux_cfg = MUX_CFG_NET;
    for (int i = CFG_W - 1; i >= 0; i--) apb(1'b1, ADDR_SHIFT, {31'h0, c[i]});
    apb(1'b0, ADDR_SHIFT, 32'h0);
    chk(rd[6:0], 7'h4c);
    apb(1'b1, ADDR_CTRL, 32'h3);
    dm = 1'b1;
    chk(cfg_out, c);
    for (int k = 0; k < CFG_WORDS; k++) begin
      apb(1'b0, ADDR_CFG0 + 12'(4 * k), 32'h0);
      chk(rd, 32'(c >> (32 * k)));
    end
    tgl();
    for (int g = 0; g < NUM_GLB; g++) ct(g, hs(c.src[g]));
    lk(40);
    tgl();
    for (int g = 0; g < NUM_GLB; g++) ct(g, int'(c.div[DIV_OUT0 + g]) + 1);
    ct(3, 0);
    ct(4, 0);
    sl();
    repeat (20) @(negedge clock);
    mon = 1'b1;
    sw(1'b1, 1'b0, 7);
    sw(1'b0, 1'b1, 7);
    sw(1'b0, 1'b0, hs(c.src[0]));
    print_verdict();
  end
endmodule // tb_glitchless_clock_conditioning
